// [design/pwmgs_cfg.svh]
// offsets, field positions, reset values and counts of the pwm generator status and override block
`ifndef PWMGS_CFG_SVH
`define PWMGS_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PWMGS_OFS_STATUS 12'h000
`define PWMGS_OFS_OVRCTL 12'h004
`define PWMGS_OFS_CAPTURE 12'h008
`define PWMGS_OFS_IRQ_STATUS 12'h00c
`define PWMGS_OFS_IRQ_MASK 12'h010
`define PWMGS_OFS_CTRL 12'h014

// ----------------------------------------------------------------
// generator status fields
// ----------------------------------------------------------------
`define PWMGS_ST_EVT_LSB 12
`define PWMGS_ST_LIVE_LSB 8
`define PWMGS_ST_SW_TRIGGER_SET 7
`define PWMGS_ST_SW_TRIGGER_CLEAR 6
`define PWMGS_ST_CAP 5
`define PWMGS_ST_UPD_PEND 4
`define PWMGS_ST_UPD_REQ 3
`define PWMGS_ST_STEER 2
`define PWMGS_ST_HALF 1
`define PWMGS_ST_TRIG 0

// ----------------------------------------------------------------
// interrupt status fields, events in bits 3..0 in the order of status bits 15..12
// ----------------------------------------------------------------
`define PWMGS_IRQ_CAP 4
`define PWMGS_IRQ_UPD 5
`define PWMGS_IRQ_W 6

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PWMGS_CT_EN 0
`define PWMGS_CT_PUSHPULL 1
`define PWMGS_CT_CENTRE 2
`define PWMGS_CT_BUM_LSB 4

// ----------------------------------------------------------------
// reset values and sync codes
// ----------------------------------------------------------------
`define PWMGS_RST_OVRCTL 16'h0000
`define PWMGS_RST_CTRL 7'h00
`define PWMGS_RST_IRQ 6'h00
`define PWMGS_OVERRIDE_SYNC_SELECT_SOC 2'h0
`define PWMGS_OVERRIDE_SYNC_SELECT_NOW 2'h1
`define PWMGS_OVERRIDE_SYNC_SELECT_BUM 2'h2
`define PWMGS_NUM_CH 4

`endif

// [design/pwmgs_pkg.sv]
// types shared by the pwm generator status and override block
package pwmgs_pkg;

	// high and low pin pair
	typedef struct packed {
		logic hi;
		logic lo;
	} pwmgs_pins_t;

	// output override control word, bit 15 first
	typedef struct packed {
		logic current_limit_invert_mode;
		logic swap;
		logic ovr_en_h;
		logic ovr_en_l;
		pwmgs_pins_t ovr_data;
		logic [1:0] ovr_sync;
		pwmgs_pins_t fault_data;
		pwmgs_pins_t cl_data;
		pwmgs_pins_t ff_data;
		pwmgs_pins_t dbg_data;
	} pwmgs_ovr_t;

	// conditions from the control-input functions, sync first
	typedef struct packed {
		logic sync;
		logic fault;
		logic climit;
		logic ffwd;
	} pwmgs_pci_t;

endpackage

// [design/pwmgs_evt.sv]
// sticky event flags and live status for a group of control-input functions
`timescale 1ns/1ps
module pwmgs_evt #(
	parameter int N = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic [N-1:0] level_i,
	input wire logic [N-1:0] clear_i,
	output logic [N-1:0] flag_o,
	output logic [N-1:0] rise_o,
	output logic [N-1:0] live_o
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (N < 1 || N > 16)
	begin : g_bad_n
		$error("pwmgs_evt: N out of range");
	end

	logic [N-1:0] prev_r;

	for (genvar i = 0; i < N; i++)
	begin : g_ch
		// previous level, held low while disabled so a high level at enable counts as an edge
		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				prev_r[i] <= 1'b0;
			else
				prev_r[i] <= enable_i & level_i[i];
		end

		// live copy of the level
		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				live_o[i] <= 1'b0;
			else
				live_o[i] <= level_i[i];
		end

		// one-cycle edge pulse
		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				rise_o[i] <= 1'b0;
			else
				rise_o[i] <= enable_i & level_i[i] & ~prev_r[i];
		end

		// sticky flag, a new edge wins over the clear
		always_ff @(posedge clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				flag_o[i] <= 1'b0;
			else if (enable_i & level_i[i] & ~prev_r[i])
				flag_o[i] <= 1'b1;
			else if (clear_i[i])
				flag_o[i] <= 1'b0;
		end
	end

endmodule

// [design/pwmgs_ovr.sv]
// output pin steering: swap, override, fault, current-limit, feed-forward and debug substitution
`timescale 1ns/1ps
`include "pwmgs_cfg.svh"
module pwmgs_ovr (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire pwmgs_pkg::pwmgs_ovr_t ctl_i,
	input wire logic [2:0] bum_i,
	input wire logic soc_i,
	input wire pwmgs_pkg::pwmgs_pins_t gen_i,
	input wire pwmgs_pkg::pwmgs_pci_t act_i,
	input wire logic debug_i,
	output pwmgs_pkg::pwmgs_pins_t pins_o
);

	// applied override state
	logic app_en_h_r;
	logic app_en_l_r;
	pwmgs_pkg::pwmgs_pins_t app_data_r;
	logic take;
	pwmgs_pkg::pwmgs_pins_t sw;
	pwmgs_pkg::pwmgs_pins_t nxt;

	// ----------------------------------------------------------------
	// override timing
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (ctl_i.ovr_sync)
			`PWMGS_OVERRIDE_SYNC_SELECT_NOW: take = 1'b1;
			`PWMGS_OVERRIDE_SYNC_SELECT_SOC: take = soc_i;
			`PWMGS_OVERRIDE_SYNC_SELECT_BUM: take = bum_i[0] | soc_i;
			default: take = 1'b0;
		endcase
	end

	// latch the written override into the applied copy
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			app_en_h_r <= 1'b0;
			app_en_l_r <= 1'b0;
			app_data_r <= '0;
		end
		else if (take)
		begin
			app_en_h_r <= ctl_i.ovr_en_h;
			app_en_l_r <= ctl_i.ovr_en_l;
			app_data_r <= ctl_i.ovr_data;
		end
	end

	// ----------------------------------------------------------------
	// pin selection, fault first, then current limit, feed-forward, debug, user override
	// ----------------------------------------------------------------
	always_comb
	begin
		sw.hi = ctl_i.swap ? gen_i.lo : gen_i.hi;
		sw.lo = ctl_i.swap ? gen_i.hi : gen_i.lo;
		nxt = sw;
		if (act_i.fault)
			nxt = ctl_i.fault_data;
		else if (act_i.climit)
			nxt = ctl_i.current_limit_invert_mode ? ~sw : ctl_i.cl_data;
		else if (act_i.ffwd)
			nxt = ctl_i.ff_data;
		else
		begin
			if (app_en_h_r)
				nxt.hi = app_data_r.hi;
			if (app_en_l_r)
				nxt.lo = app_data_r.lo;
			if (debug_i)
				nxt = ctl_i.dbg_data;
		end
	end

	// registered pins
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pins_o <= '0;
		else
			pins_o <= nxt;
	end

endmodule

// [design/pwmgs_top.sv]
// pwm generator status and output override block with apb register access
// Functional notes
// - sync, current-limit, feed-forward event flags behave like the fault flag.
// - four live status bits follow their control-input levels.
// - writing one to capture flag latches time base and sets flag on the same clock.
// - no further capture until software clears the capture flag.
// - update pending reads one and blocks user data writes while pending.
// - update request bit reads zero and sets update pending until transfer.
// - steering bit shows second (1) or first (0) push-pull cycle.
// - half-cycle bit shows second (1) or first (0) time base half.
// - trigger status is one while triggered and a cycle runs.
// - low pin override enable drives low pin from override data bit.
// - two-bit override data: upper bit high pin, lower bit low pin.
// - override sync: 10 buffer mode, 01 immediate, 00 next start of cycle.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pwmgs_cfg.svh"
module pwmgs_top #(
	parameter int TB_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire pwmgs_pkg::pwmgs_pci_t pci_i,
	input wire logic debug_i,
	input wire logic soc_i,
	input wire logic eoc_i,
	input wire logic tb_second_half_i,
	input wire logic [TB_W-1:0] timebase_i,
	input wire pwmgs_pkg::pwmgs_pins_t gen_i,
	output pwmgs_pkg::pwmgs_pins_t pins_o,
	output logic cycle_active_o,
	output logic data_write_block_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (TB_W < 1 || TB_W > 32)
	begin : g_bad_tb
		$error("pwmgs_top: TB_W out of range");
	end

	localparam int NC = `PWMGS_NUM_CH;

	pwmgs_pkg::pwmgs_ovr_t ovr_r;
	logic [6:0] ctrl_r;
	logic [`PWMGS_IRQ_W-1:0] irq_st_r;
	logic [`PWMGS_IRQ_W-1:0] irq_mask_r;
	logic [`PWMGS_IRQ_W-1:0] irq_set;
	logic [TB_W-1:0] cap_r;
	logic cap_flag_r;
	logic cap_req_r;
	logic upd_pend_r;
	logic trig_r;
	logic steer_r;
	logic half_r;
	logic [NC-1:0] evt_flag;
	logic [NC-1:0] evt_rise;
	logic [NC-1:0] evt_live;
	logic [NC-1:0] evt_clr;
	logic setup;
	logic wr;
	logic wr_st;
	logic mapped;
	logic enable;
	logic upd_done;
	logic [31:0] rd_mux;

	assign enable = ctrl_r[`PWMGS_CT_EN];

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// setup phase is decoded, the access phase answers in its first cycle
	assign setup = psel_i & ~penable_i;
	assign wr = psel_i & penable_i & pwrite_i & pready_o & ~pslverr_o;
	assign wr_st = wr && (paddr_i == `PWMGS_OFS_STATUS);

	// address decode and read data, word aligned offsets only
	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr_i)
			`PWMGS_OFS_STATUS:
			begin
				rd_mux[`PWMGS_ST_EVT_LSB +: NC] = evt_flag;
				rd_mux[`PWMGS_ST_LIVE_LSB +: NC] = evt_live;
				rd_mux[`PWMGS_ST_CAP] = cap_flag_r;
				rd_mux[`PWMGS_ST_UPD_PEND] = upd_pend_r;
				rd_mux[`PWMGS_ST_STEER] = steer_r;
				rd_mux[`PWMGS_ST_HALF] = half_r;
				rd_mux[`PWMGS_ST_TRIG] = trig_r;
			end
			`PWMGS_OFS_OVRCTL: rd_mux[15:0] = ovr_r;
			`PWMGS_OFS_CAPTURE: rd_mux[TB_W-1:0] = cap_r;
			`PWMGS_OFS_IRQ_STATUS: rd_mux[`PWMGS_IRQ_W-1:0] = irq_st_r;
			`PWMGS_OFS_IRQ_MASK: rd_mux[`PWMGS_IRQ_W-1:0] = irq_mask_r;
			`PWMGS_OFS_CTRL: rd_mux[6:0] = ctrl_r;
			default: mapped = 1'b0;
		endcase
	end

	// ready pulse for the first access cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pready_o <= 1'b0;
		else
			pready_o <= setup;
	end

	// error on unmapped address
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pslverr_o <= 1'b0;
		else
			pslverr_o <= setup & ~mapped;
	end

	// read data captured in the setup cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			prdata_o <= 32'h0000_0000;
		else if (setup)
			prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	// output override control
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ovr_r <= `PWMGS_RST_OVRCTL;
		else if (wr && paddr_i == `PWMGS_OFS_OVRCTL)
			ovr_r <= pwdata_i[15:0];
	end

	// block control
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_r <= `PWMGS_RST_CTRL;
		else if (wr && paddr_i == `PWMGS_OFS_CTRL)
			ctrl_r <= pwdata_i[6:0];
	end

	// interrupt mask
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_mask_r <= `PWMGS_RST_IRQ;
		else if (wr && paddr_i == `PWMGS_OFS_IRQ_MASK)
			irq_mask_r <= pwdata_i[`PWMGS_IRQ_W-1:0];
	end

	// ----------------------------------------------------------------
	// event flags, cleared by writing zero to the flag
	// ----------------------------------------------------------------
	assign evt_clr = wr_st ? ~pwdata_i[`PWMGS_ST_EVT_LSB +: NC] : '0;

	pwmgs_evt #(
		.N(NC)
	) u_evt (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.enable_i(enable),
		.level_i(pci_i),
		.clear_i(evt_clr),
		.flag_o(evt_flag),
		.rise_o(evt_rise),
		.live_o(evt_live)
	);

	// ----------------------------------------------------------------
	// software capture
	// ----------------------------------------------------------------
	// request armed by a write of one while the flag is clear
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cap_req_r <= 1'b0;
		else if (cap_req_r)
			cap_req_r <= 1'b0;
		else if (wr_st && pwdata_i[`PWMGS_ST_CAP] && !cap_flag_r)
			cap_req_r <= 1'b1;
	end

	// captured time base value
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cap_r <= '0;
		else if (cap_req_r)
			cap_r <= timebase_i;
	end

	// capture flag, cleared by writing zero, the capture itself wins
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cap_flag_r <= 1'b0;
		else if (cap_req_r)
			cap_flag_r <= 1'b1;
		else if (wr_st && !pwdata_i[`PWMGS_ST_CAP])
			cap_flag_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// data update request
	// ----------------------------------------------------------------
	// transfer at start of cycle, or on the next clock in an immediate buffer mode
	assign upd_done = upd_pend_r & (soc_i | ctrl_r[`PWMGS_CT_BUM_LSB]);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			upd_pend_r <= 1'b0;
		else if (wr_st && pwdata_i[`PWMGS_ST_UPD_REQ])
			upd_pend_r <= 1'b1;
		else if (upd_done)
			upd_pend_r <= 1'b0;
	end

	// blocks user duty, period and phase writes outside this block
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			data_write_block_o <= 1'b0;
		else
			data_write_block_o <= upd_pend_r | (wr_st & pwdata_i[`PWMGS_ST_UPD_REQ]);
	end

	// ----------------------------------------------------------------
	// trigger, steering and half-cycle state
	// ----------------------------------------------------------------
	// set by software or start of cycle, ended by software, end of cycle or disable
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			trig_r <= 1'b0;
		else if (!enable)
			trig_r <= 1'b0;
		else if ((wr_st && pwdata_i[`PWMGS_ST_SW_TRIGGER_SET]) || soc_i)
			trig_r <= 1'b1;
		else if ((wr_st && pwdata_i[`PWMGS_ST_SW_TRIGGER_CLEAR]) || eoc_i)
			trig_r <= 1'b0;
	end

	assign cycle_active_o = trig_r;

	// push-pull cycle toggles at every end of cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			steer_r <= 1'b0;
		else if (!ctrl_r[`PWMGS_CT_PUSHPULL] || !enable)
			steer_r <= 1'b0;
		else if (eoc_i)
			steer_r <= ~steer_r;
	end

	// second half of the centre-aligned time base
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			half_r <= 1'b0;
		else
			half_r <= ctrl_r[`PWMGS_CT_CENTRE] & enable & tb_second_half_i;
	end

	// ----------------------------------------------------------------
	// interrupts, set wins over write-one-to-clear
	// ----------------------------------------------------------------
	always_comb
	begin
		irq_set = '0;
		irq_set[NC-1:0] = evt_rise;
		irq_set[`PWMGS_IRQ_CAP] = cap_req_r;
		irq_set[`PWMGS_IRQ_UPD] = upd_done;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_st_r <= `PWMGS_RST_IRQ;
		else if (wr && paddr_i == `PWMGS_OFS_IRQ_STATUS)
			irq_st_r <= (irq_st_r & ~pwdata_i[`PWMGS_IRQ_W-1:0]) | irq_set;
		else
			irq_st_r <= irq_st_r | irq_set;
	end

	// level interrupt output
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |((irq_st_r | irq_set) & irq_mask_r);
	end

	// ----------------------------------------------------------------
	// output pins
	// ----------------------------------------------------------------
	pwmgs_ovr u_ovr (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ctl_i(ovr_r),
		.bum_i(ctrl_r[`PWMGS_CT_BUM_LSB +: 3]),
		.soc_i(soc_i),
		.gen_i(gen_i),
		.act_i(pci_i),
		.debug_i(debug_i),
		.pins_o(pins_o)
	);

endmodule

// [tb/pwmgs_gate_model.sv]
// power stage model: gate drivers that follow the high and low output pins
`timescale 1ns/1ps
module pwmgs_gate_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire pwmgs_pkg::pwmgs_pins_t pins_i,
	output logic overlap_o
);
	// both switches on conducts straight through the stage; flag it
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			overlap_o <= 1'b0;
		else
			overlap_o <= pins_i.hi & pins_i.lo;
	end
endmodule

// [tb/pwmgs_top_props.sv]
// concurrent checks on the ports of the status and override block
`timescale 1ns/1ps
module pwmgs_top_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire pwmgs_pkg::pwmgs_pci_t pci_i,
	input wire logic soc_i,
	input wire logic eoc_i,
	input wire logic cycle_active_o,
	input wire logic data_write_block_o
);
	logic stat_wr;
	logic stat_rd;
	logic en_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// completed write to the status register
	assign stat_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h000;
	// answered read of the status register
	assign stat_rd = pready_o && !pwrite_i && paddr_i == 12'h000;

	// enable bit as last written to the control register; start of cycle only counts while enabled
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			en_r <= 1'b0;
		else if (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o && paddr_i == 12'h014)
			en_r <= pwdata_i[0];
	end

	sequence setup_s;
		psel_i && !penable_i;
	endsequence
	sequence stat_rd_s;
		setup_s ##0 (!pwrite_i && paddr_i == 12'h000 && $stable(pci_i));
	endsequence

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	apb_ready_a: assert property (setup_s |=> pready_o) else $error("no ready after setup");
	ready_pulse_a: assert property ($rose(pready_o) |=> !pready_o) else $error("ready held too long");
	slverr_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
	err_data_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0) else $error("refused read data");
	// ----------------------------------------------------------------
	// status register behaviour
	// ----------------------------------------------------------------
	stat_zero_a: assert property (stat_rd |-> prdata_o[7:6] == 2'b00 && !prdata_o[3])
		else $error("write-only status bits read one");
	live_read_a: assert property (stat_rd_s |=> prdata_o[11:8] == $past(pci_i))
		else $error("live status wrong");
	trig_set_a: assert property (soc_i && en_r |=> cycle_active_o) else $error("cycle not active after start");
	trig_clr_a: assert property (eoc_i && !soc_i && !(stat_wr && pwdata_i[7]) |=> !cycle_active_o)
		else $error("cycle active after end");
	upd_block_a: assert property (stat_wr && pwdata_i[3] |-> ##2 data_write_block_o)
		else $error("data writes not blocked");
endmodule

bind pwmgs_top pwmgs_top_props props (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .pci_i(pci_i), .soc_i(soc_i), .eoc_i(eoc_i), .cycle_active_o(cycle_active_o),
	.data_write_block_o(data_write_block_o));

// [tb/pwmgs_bench.sv]
// self-checking bench of the status and override block
`timescale 1ns/1ps
`include "pwmgs_cfg.svh"
module pwmgs_bench;
	logic clk_i, rst_n_i, psel, penable, pwrite, debug, soc, eoc, half, pready, pslverr, cyc, blk, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] tbase;
	logic [1:0] prv;
	pwmgs_pkg::pwmgs_pci_t pci;
	pwmgs_pkg::pwmgs_pins_t gen, pins;
	int err_count, check_count, i;
	logic ovl;
	localparam logic [11:0] st = `PWMGS_OFS_STATUS;

	// 100 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	pwmgs_top #(.TB_W(16)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .pci_i(pci), .debug_i(debug), .soc_i(soc), .eoc_i(eoc), .tb_second_half_i(half),
		.timebase_i(tbase), .gen_i(gen), .pins_o(pins), .cycle_active_o(cyc), .data_write_block_o(blk), .irq_o(irq));
	pwmgs_gate_model gate (.clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .overlap_o(ovl));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until ready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			err_count++;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rdat, x);
	endtask
	// start-of-cycle (0) or end-of-cycle (1) pulse
	task pulse(input logic which);
		@(posedge clk_i);
		soc <= !which;
		eoc <= which;
		@(posedge clk_i);
		soc <= 1'b0;
		eoc <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task summarize;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, debug, soc, eoc, half} = '0;
		paddr = '0;
		pwdata = '0;
		tbase = 16'h1234;
		pci = '0;
		gen = 2'b10;
		prv = 2'b11;
		err_count = 0;
		check_count = 0;
		rst_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(st, 32'h0);
		rd(`PWMGS_OFS_OVRCTL, 32'h0);
		rd(12'h040, 32'h0);
		chk(32'(e), 32'h1);
		// a level already high when the block is enabled counts as an edge
		pci <= 4'h8;
		repeat (3) @(posedge clk_i);
		rd(st, 32'h0800);
		wr(`PWMGS_OFS_CTRL, 32'h1);
		repeat (2) @(posedge clk_i);
		rd(st, 32'h8800);
		pci <= 4'h0;
		wr(st, 32'h0);
		// each input function: live level and sticky flag, then cleared by software
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk_i);
			pci <= 4'h1 << i;
			repeat (3) @(posedge clk_i);
			rd(st, 32'h1100 << i);
			@(posedge clk_i);
			pci <= 4'h0;
			repeat (3) @(posedge clk_i);
			rd(st, 32'h1000 << i);
			wr(st, 32'h0);
			rd(st, 32'h0);
		end
		// interrupt held back by the mask, raised once enabled, then cleared
		rd(`PWMGS_OFS_IRQ_STATUS, 32'hf);
		chk(32'(irq), 32'h0);
		wr(`PWMGS_OFS_IRQ_MASK, 32'h3f);
		repeat (2) @(posedge clk_i);
		chk(32'(irq), 32'h1);
		wr(`PWMGS_OFS_IRQ_STATUS, 32'h3f);
		repeat (2) @(posedge clk_i);
		chk(32'(irq), 32'h0);
		rd(`PWMGS_OFS_IRQ_STATUS, 32'h0);
		// capture, refused while flagged, re-armed after clear
		wr(st, 32'h20);
		rd(`PWMGS_OFS_CAPTURE, 32'h1234);
		rd(st, 32'h20);
		tbase <= 16'h5678;
		wr(st, 32'h20);
		rd(`PWMGS_OFS_CAPTURE, 32'h1234);
		wr(st, 32'h0);
		wr(st, 32'h20);
		rd(`PWMGS_OFS_CAPTURE, 32'h5678);
		rd(`PWMGS_OFS_IRQ_STATUS, 32'h10);
		chk(32'(irq), 32'h1);
		// update request, pending until start of cycle; trigger set and clear
		wr(st, 32'h8);
		repeat (2) @(posedge clk_i);
		rd(st, 32'h10);
		chk(32'(blk), 32'h1);
		pulse(1'b0);
		rd(st, 32'h1);
		chk(32'(blk), 32'h0);
		rd(`PWMGS_OFS_IRQ_STATUS, 32'h30);
		pulse(1'b1);
		rd(st, 32'h0);
		wr(st, 32'h80);
		rd(st, 32'h1);
		chk(32'(cyc), 32'h1);
		wr(st, 32'h40);
		rd(st, 32'h0);
		// steering in push-pull, half cycle in centre-aligned
		wr(`PWMGS_OFS_CTRL, 32'h3);
		pulse(1'b1);
		rd(st, 32'h4);
		pulse(1'b1);
		rd(st, 32'h0);
		wr(`PWMGS_OFS_CTRL, 32'h5);
		half <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd(st, 32'h2);
		half <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(st, 32'h0);
		// user overrides and their timing codes
		wr(`PWMGS_OFS_CTRL, 32'h1);
		wr(`PWMGS_OFS_OVRCTL, 32'h1500);
		repeat (3) @(posedge clk_i);
		chk(32'(pins), 32'h3);
		@(posedge clk_i);
		chk(32'(ovl), 32'h1);
		for (i = 0; i < 3; i++)
		begin
			wr(`PWMGS_OFS_OVRCTL, 32'h3000 | (i << 8) | ((i + 1) << 10));
			repeat (3) @(posedge clk_i);
			chk(32'(pins), (i == 1) ? 32'(i + 1) : 32'(prv));
			pulse(1'b0);
			chk(32'(pins), 32'(i + 1));
			prv = 2'(i + 1);
		end
		// immediate buffer mode: code 10 and the update request act at once, code 11 keeps the old override
		wr(`PWMGS_OFS_CTRL, 32'h11);
		wr(`PWMGS_OFS_OVRCTL, 32'h3a00);
		repeat (3) @(posedge clk_i);
		chk(32'(pins), 32'h2);
		wr(`PWMGS_OFS_OVRCTL, 32'h3300);
		repeat (3) @(posedge clk_i);
		chk(32'(pins), 32'h2);
		wr(st, 32'h8);
		rd(st, 32'h1);
		wr(`PWMGS_OFS_OVRCTL, 32'h4100);
		repeat (3) @(posedge clk_i);
		chk(32'(pins), 32'h1);
		// substitute data for fault, current limit, feed-forward and debug
		gen <= 2'b01;
		for (i = 0; i < 4; i++)
		begin
			wr(`PWMGS_OFS_OVRCTL, 32'h0100 | (32'h80 >> (2 * i)));
			pci <= (i < 3) ? 4'h4 >> i : 4'h0;
			debug <= (i == 3);
			repeat (3) @(posedge clk_i);
			chk(32'(pins), 32'h2);
			pci <= 4'h0;
			debug <= 1'b0;
		end
		wr(`PWMGS_OFS_OVRCTL, 32'h8100);
		pci <= 4'h2;
		repeat (3) @(posedge clk_i);
		chk(32'(pins), 32'h2);
		@(posedge clk_i);
		chk(32'(ovl), 32'h0);
		summarize();
	end
endmodule
